// file: src/msc_defines.svh
`ifndef MSC_DEFINES_SVH
`define MSC_DEFINES_SVH
// register byte offsets
`define MSC_OFF_A 12'h000
`define MSC_OFF_B 12'h004
`define MSC_OFF_STAT 12'h008
// reset values
`define MSC_RST_A 16'h0fff
`define MSC_RST_B 16'hffff
// reserved bits forced to one
`define MSC_RSV_A 16'h00de
`define MSC_RSV_B 16'h601f
// field positions
`define MSC_ALL_STOP_EN_BIT 15
`define MSC_DMA_BIT 13
`define MSC_XFER_BIT 12
`define MSC_TIMER_LO 8
`define MSC_DAC_BIT 5
`define MSC_PULSE_TIMER_BIT 0
`define MSC_PULSE_GEN_BIT 15
`define MSC_SERIAL_LO 8
`define MSC_I2C0_BIT 6
`define MSC_BRK_BIT 5
`define MSC_RESP_OKAY 2'b00
`define MSC_RESP_SLVERR 2'b10
`endif

// file: src/msc_pkg.sv
package msc_pkg;
  typedef struct packed {
    logic dma;
    logic transfer_ctrl;
    logic [3:0] timer;
    logic dac;
    logic pulse_timer;
    logic pulse_gen;
    logic [4:0] serial;
    logic [1:0] i2c;
    logic break_ctrl;
  } msc_stop_s;
  typedef enum logic [1:0] {
    MSC_RUN = 2'b00,
    MSC_ALL_STOP = 2'b01
  } msc_mode_e;
  typedef struct packed {
    logic [15:0] ctrl_a;
    logic [15:0] ctrl_b;
    msc_mode_e mode;
    logic awv;
    logic [11:0] awaddr;
    logic wv;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } msc_state_s;
endpackage

// file: src/msc_top.sv
// Functional notes
// - one stops a module, zero releases it
// - enable plus all stopped plus sleep raises all_clock_stop
// - all-clock-stop enable resets to zero
// - bits 13,12 gate dma, transfer; reset zero
// - bits 11..8 gate timer pairs; reset one
// - bit 5 gates converter; reset one
// - bit 0 gates pulse timer; reset one
// - register a reserved bits read one
// - register b bit 15 gates pulse generator
// - bits 12..8 gate serial channels
// - bits 7,6 gate i2c ports one, zero
// - bit 5 gates break controller
// - register b reserved bits read one
`timescale 1ns/100ps
`default_nettype none
`include "msc_defines.svh"
module msc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_exec,
  output msc_pkg::msc_stop_s module_stop,
  output logic all_clock_stop
);
  import msc_pkg::*;

  msc_state_s st_reg;
  msc_state_s st_next;
  logic do_write;
  logic do_read;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // reserved bits are forced so they always read one
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0] be,
                                          input logic [15:0] rsv);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end
    if (be[1]) begin
      v[15:8] = wd[15:8];
    end
    merge16 = v | rsv;
  endfunction

  function automatic logic all_stopped(input logic [15:0] a,
                                       input logic [15:0] b);
    all_stopped = (&(a[14:0] | 15'h4000)) && (&b);
  endfunction

  // read and write paths share one address decode
  function automatic logic [9:0] word_index(input logic [11:0] off);
    word_index = off[11:2];
  endfunction

  // ----------------------------------------
  // bus handshakes
  // ----------------------------------------
  // address and data latch separately so either may come first
  assign s_axi_awready = !st_reg.awv && !st_reg.bvalid;
  assign s_axi_wready = !st_reg.wv && !st_reg.bvalid;
  assign s_axi_arready = !st_reg.rvalid;
  assign do_write = st_reg.awv && st_reg.wv && !st_reg.bvalid;
  assign do_read = s_axi_arvalid && !st_reg.rvalid;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.awv = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.wv = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      st_next.awv = 1'b0;
      st_next.wv = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = `MSC_RESP_OKAY;
      case (st_reg.awaddr[11:2])
        word_index(`MSC_OFF_A): begin
          st_next.ctrl_a = merge16(st_reg.ctrl_a, st_reg.wdata[15:0],
                                   st_reg.wstrb[1:0], `MSC_RSV_A);
        end
        word_index(`MSC_OFF_B): begin
          st_next.ctrl_b = merge16(st_reg.ctrl_b, st_reg.wdata[15:0],
                                   st_reg.wstrb[1:0], `MSC_RSV_B);
        end
        word_index(`MSC_OFF_STAT): begin
        end
        default: begin
          st_next.bresp = `MSC_RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (do_read) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = `MSC_RESP_OKAY;
      st_next.rdata = 32'h0;
      case (s_axi_araddr[11:2])
        word_index(`MSC_OFF_A): begin
          st_next.rdata = {16'h0, st_reg.ctrl_a | `MSC_RSV_A};
        end
        word_index(`MSC_OFF_B): begin
          st_next.rdata = {16'h0, st_reg.ctrl_b | `MSC_RSV_B};
        end
        word_index(`MSC_OFF_STAT): begin
          st_next.rdata = {31'h0, st_reg.mode == MSC_ALL_STOP};
        end
        default: begin
          st_next.rresp = `MSC_RESP_SLVERR;
        end
      endcase
    end
    // all-clock-stop entered on sleep, left when sleep drops
    case (st_reg.mode)
      MSC_RUN: begin
        if (sleep_exec && st_reg.ctrl_a[`MSC_ALL_STOP_EN_BIT]
            && all_stopped(st_reg.ctrl_a, st_reg.ctrl_b)) begin
          st_next.mode = MSC_ALL_STOP;
        end
      end
      MSC_ALL_STOP: begin
        if (!sleep_exec) begin
          st_next.mode = MSC_RUN;
        end
      end
      default: begin
        st_next.mode = MSC_RUN;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.ctrl_a <= `MSC_RST_A;
      st_reg.ctrl_b <= `MSC_RST_B;
      st_reg.mode <= MSC_RUN;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign all_clock_stop = (st_reg.mode == MSC_ALL_STOP);

  always_comb begin
    module_stop.dma = st_reg.ctrl_a[`MSC_DMA_BIT];
    module_stop.transfer_ctrl = st_reg.ctrl_a[`MSC_XFER_BIT];
    module_stop.timer = st_reg.ctrl_a[`MSC_TIMER_LO +: 4];
    module_stop.dac = st_reg.ctrl_a[`MSC_DAC_BIT];
    module_stop.pulse_timer = st_reg.ctrl_a[`MSC_PULSE_TIMER_BIT];
    module_stop.pulse_gen = st_reg.ctrl_b[`MSC_PULSE_GEN_BIT];
    module_stop.serial = st_reg.ctrl_b[`MSC_SERIAL_LO +: 5];
    module_stop.i2c = st_reg.ctrl_b[`MSC_I2C0_BIT +: 2];
    module_stop.break_ctrl = st_reg.ctrl_b[`MSC_BRK_BIT];
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_stop_follow;
    @(posedge aclk) disable iff (!aresetn)
    (do_write && st_reg.awaddr == `MSC_OFF_A && st_reg.wstrb[1])
      |=> module_stop.dma == $past(st_reg.wdata[13])
      && module_stop.timer == $past(st_reg.wdata[11:8]);
  endproperty
  a_stop_follow: assert property (p_stop_follow)
    else $error("stop output does not follow register");

  property p_all_stop;
    @(posedge aclk) disable iff (!aresetn)
    (sleep_exec && !all_clock_stop && st_reg.ctrl_a[15]
     && (&st_reg.ctrl_a[13:0]) && (&st_reg.ctrl_b)) |=> all_clock_stop;
  endproperty
  a_all_stop: assert property (p_all_stop)
    else $error("all clock stop not entered");

  property p_no_stop_acse0;
    @(posedge aclk) disable iff (!aresetn)
    (!all_clock_stop && !st_reg.ctrl_a[15]) |=> !all_clock_stop;
  endproperty
  a_no_stop_acse0: assert property (p_no_stop_acse0)
    else $error("all clock stop entered while disabled");

  property p_reset_a;
    @(posedge aclk) $rose(aresetn) |-> st_reg.ctrl_a == 16'h0fff;
  endproperty
  a_reset_a: assert property (p_reset_a)
    else $error("register a reset value wrong");

  property p_reset_b;
    @(posedge aclk) $rose(aresetn) |-> module_stop.serial == 5'h1f
      && module_stop.i2c == 2'h3 && module_stop.break_ctrl;
  endproperty
  a_reset_b: assert property (p_reset_b)
    else $error("register b reset value wrong");

  property p_rsv_a;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == `MSC_OFF_A)
      |=> (s_axi_rdata[15:0] & `MSC_RSV_A) == `MSC_RSV_A;
  endproperty
  a_rsv_a: assert property (p_rsv_a)
    else $error("reserved bits read wrong");

  property p_rsv_b;
    @(posedge aclk) disable iff (!aresetn)
    (st_reg.ctrl_b & 16'h601f) == 16'h601f;
  endproperty
  a_rsv_b: assert property (p_rsv_b)
    else $error("register b reserved bits cleared");

  property p_rsv_a_hold;
    @(posedge aclk) disable iff (!aresetn)
    (st_reg.ctrl_a & `MSC_RSV_A) == `MSC_RSV_A;
  endproperty
  a_rsv_a_hold: assert property (p_rsv_a_hold)
    else $error("register a reserved bits cleared");

  property p_bresp;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write response dropped early");

  property p_write_a_lo;
    @(posedge aclk) disable iff (!aresetn)
    (do_write && st_reg.awaddr == `MSC_OFF_A && st_reg.wstrb[0])
      |=> module_stop.dac == $past(st_reg.wdata[5])
      && module_stop.pulse_timer == $past(st_reg.wdata[0]);
  endproperty
  a_write_a_lo: assert property (p_write_a_lo)
    else $error("register a low byte write not applied");

  property p_write_b_hi;
    @(posedge aclk) disable iff (!aresetn)
    (do_write && st_reg.awaddr == `MSC_OFF_B && st_reg.wstrb[1])
      |=> module_stop.pulse_gen == $past(st_reg.wdata[15])
      && module_stop.serial == $past(st_reg.wdata[12:8]);
  endproperty
  a_write_b_hi: assert property (p_write_b_hi)
    else $error("register b high byte write not applied");

  property p_write_b_lo;
    @(posedge aclk) disable iff (!aresetn)
    (do_write && st_reg.awaddr == `MSC_OFF_B && st_reg.wstrb[0])
      |=> module_stop.i2c == $past(st_reg.wdata[7:6])
      && module_stop.break_ctrl == $past(st_reg.wdata[5]);
  endproperty
  a_write_b_lo: assert property (p_write_b_lo)
    else $error("register b low byte write not applied");

  property p_all_clock_stop_enable_reset;
    @(posedge aclk) $rose(aresetn)
      |-> !st_reg.ctrl_a[15] && !all_clock_stop;
  endproperty
  a_all_clock_stop_enable_reset: assert property (p_all_clock_stop_enable_reset)
    else $error("all clock stop enable not clear after reset");

  property p_reset_timers;
    @(posedge aclk) $rose(aresetn) |-> module_stop.timer == 4'hf
      && module_stop.dac && module_stop.pulse_timer;
  endproperty
  a_reset_timers: assert property (p_reset_timers)
    else $error("timer or converter stop bits wrong after reset");

  property p_reset_pg;
    @(posedge aclk) $rose(aresetn) |-> module_stop.pulse_gen
      && !module_stop.dma && !module_stop.transfer_ctrl;
  endproperty
  a_reset_pg: assert property (p_reset_pg)
    else $error("pulse generator or transfer stop bits wrong after reset");

  property p_all_stop_leave;
    @(posedge aclk) disable iff (!aresetn)
    (all_clock_stop && !sleep_exec) |=> !all_clock_stop;
  endproperty
  a_all_stop_leave: assert property (p_all_stop_leave)
    else $error("all clock stop held after sleep ended");

  property p_all_stop_need;
    @(posedge aclk) disable iff (!aresetn)
    $rose(all_clock_stop) |-> $past(sleep_exec) && $past(st_reg.ctrl_a[15])
      && (&$past(st_reg.ctrl_a[13:0])) && (&$past(st_reg.ctrl_b));
  endproperty
  a_all_stop_need: assert property (p_all_stop_need)
    else $error("all clock stop entered without its conditions");

  property p_no_stop_brk;
    @(posedge aclk) disable iff (!aresetn)
    (!all_clock_stop && !st_reg.ctrl_b[5]) |=> !all_clock_stop;
  endproperty
  a_no_stop_brk: assert property (p_no_stop_brk)
    else $error("all clock stop entered with break controller running");

  property p_ctrl_keep;
    @(posedge aclk) disable iff (!aresetn)
    (do_write && st_reg.awaddr[11:2] >= 10'h002)
      |=> $stable(st_reg.ctrl_a) && $stable(st_reg.ctrl_b);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep)
    else $error("status or unmapped write changed a control register");

endmodule
`default_nettype wire

// file: verification/msc_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
module msc_top_bench;
  import msc_pkg::*;
  logic aclk = 0, aresetn = 0, sleep_exec = 0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, acs;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  msc_stop_s stop;
  int mismatches = 0, tests_run = 0;
  logic [15:0] pat;
  logic [15:0] rsv [2] = '{16'h00de, 16'h601f};

  always #2 aclk = ~aclk;

  msc_top u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sleep_exec(sleep_exec),
    .module_stop(stop), .all_clock_stop(acs));

  // ---------------------------------------------------------------
  // compare and bus tasks
  // ---------------------------------------------------------------
  task automatic chk_val(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_stop(input msc_stop_s e);
    tests_run++;
    if (stop !== e) begin
      mismatches++;
      $display("Error module_stop expected %h got %h", e, stop);
    end
  endtask

  function automatic msc_stop_s exp_stop(input logic [15:0] a, b);
    return {a[13:8], a[5], a[0], b[15], b[12:5]};
  endfunction

  // aw and w offered together, each dropped once its own ready is seen
  task automatic wr(input logic [11:0] ad, input logic [15:0] d,
                    input logic [1:0] er);
    logic aw_ok, w_ok, got;
    logic [1:0] r;
    aw_ok = 0;
    w_ok = 0;
    got = 0;
    r = 'x;
    awaddr <= ad;
    wdata <= {16'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1;
        awvalid <= 0;
      end
      if (!w_ok && wready) begin
        w_ok = 1;
        wvalid <= 0;
      end
      if (bvalid) begin
        got = 1;
        r = bresp;
        bready <= 0;
      end
    end
    @(posedge aclk);
    chk_val("bresp", er, r);
  endtask

  // bit 14 of register a is left to the design, so it is masked off
  task automatic rd(input logic [11:0] ad, input logic [31:0] e,
                    input logic [1:0] er);
    logic ar_ok, got;
    logic [1:0] r;
    logic [31:0] d;
    ar_ok = 0;
    got = 0;
    r = 'x;
    d = 'x;
    araddr <= ad;
    arvalid <= 1;
    rready <= 1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge aclk);
      if (!ar_ok && arready) begin
        ar_ok = 1;
        arvalid <= 0;
      end
      if (rvalid) begin
        got = 1;
        r = rresp;
        d = rdata;
        rready <= 0;
      end
    end
    @(posedge aclk);
    chk_val("rresp", er, r);
    if (er == 2'b00) begin
      chk_val("rdata", e, d & ((ad == 12'h0) ? 32'hffffbfff : '1));
    end
  endtask

  task automatic slp(input logic e);
    sleep_exec <= 1;
    repeat (3) @(posedge aclk);
    chk_val("all_clock_stop", {31'h0, e}, {31'h0, acs});
    sleep_exec <= 0;
    repeat (3) @(posedge aclk);
    chk_val("all_clock_stop", 0, {31'h0, acs});
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(12'h000, 32'h0fff, 2'b00);
    rd(12'h004, 32'hffff, 2'b00);
    chk_stop(exp_stop(16'h0fff, 16'hffff));
    chk_val("all_clock_stop", 0, {31'h0, acs});
    // a walking zero moves each field both ways except register b bit 15, which only goes to zero; the last pass clears all
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 17; i++) begin
        pat = (i == 16) ? 16'h0 : ~(16'h1 << i);
        if (j == 0) begin
          pat[14] = 1'b0;
        end
        pat = pat | rsv[j];
        wr(12'(4 * j), pat, 2'b00);
        rd(12'(4 * j), {16'h0, pat | rsv[j]}, 2'b00);
        if (j == 0) begin
          chk_stop(exp_stop(pat, 16'hffff));
        end else begin
          chk_stop(exp_stop(16'h0, pat));
        end
      end
    end
    wr(12'h00c, 16'hffff, 2'b10);
    rd(12'h00c, 32'h0, 2'b10);
    rd(12'h000, 32'h00de, 2'b00);
    wr(12'h008, 16'h0001, 2'b00);
    rd(12'h008, 32'h0, 2'b00);
    wr(12'h000, 16'hbfff, 2'b00);
    wr(12'h004, 16'hffff, 2'b00);
    slp(1'b1);
    wr(12'h004, 16'hffdf, 2'b00);
    slp(1'b0);
    wr(12'h004, 16'hffff, 2'b00);
    wr(12'h000, 16'h9fff, 2'b00);
    slp(1'b0);
    wr(12'h000, 16'h3fff, 2'b00);
    slp(1'b0);
    // byte lanes: each strobe touches only its own half of register b
    wstrb <= 4'h2;
    wr(12'h004, 16'h7fff, 2'b00);
    wstrb <= 4'h1;
    wr(12'h004, 16'h601f, 2'b00);
    wstrb <= 4'hf;
    rd(12'h004, 32'h7f1f, 2'b00);
    chk_stop(exp_stop(16'h3fff, 16'h7f1f));
    // a reset in mid-run must bring back the power-up values
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(12'h000, 32'h0fff, 2'b00);
    rd(12'h004, 32'hffff, 2'b00);
    chk_stop(exp_stop(16'h0fff, 16'hffff));
    chk_val("all_clock_stop", 0, {31'h0, acs});
    finish_test();
  end

  // whole run needs a few hundred cycles; this limit cuts a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    finish_test();
  end
endmodule
`default_nettype wire
